// ### hdl/iex_core.v
// Purpose: Execution unit for a group of 8-bit core instructions:
//          skips, set, increment/decrement, subtract, swap, table read, xor.
// Assumes: Program memory answers combinationally on pmAddr while pmRd is high.
// Notes:   Software issues one instruction per EXEC write over Wishbone.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`include "iex_regs.vh"
`default_nettype none

module iex_core #(
  parameter DMEM_DEPTH = 256,
  parameter PM_ADDR_WIDTH = 12,
  parameter PM_DATA_WIDTH = 16
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [PM_ADDR_WIDTH-1:0] pmAddr,
  output reg pmRd,
  input wire [PM_DATA_WIDTH-1:0] pmData,
  output reg busy
);

  // One-hot states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_EXEC = 4'h2;
  localparam [3:0] ST_TAB = 4'h4;
  localparam [3:0] ST_DUMMY = 4'h8;
  localparam PAGE_W = PM_ADDR_WIDTH - 8;

  // Data memory, not reset: contents are software's concern
  reg [7:0] dmem [0:DMEM_DEPTH-1];

  // Architectural state
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [23:0] instr_reg; // Instruction being executed
  reg [7:0] acc_reg;
  reg [7:0] acc_next;
  reg [7:0] tptr_reg; // Table pointer
  reg [7:0] thigh_reg; // Table high byte
  reg [PAGE_W-1:0] page_reg; // Current program page
  reg [7:0] daddr_reg; // Bus window into data memory
  reg flagC_reg;
  reg flagAc_reg;
  reg flagZ_reg;
  reg flagOv_reg;
  reg flagC_next;
  reg flagAc_next;
  reg flagZ_next;
  reg flagOv_next;
  reg skipPend_reg; // Next issued instruction is discarded
  reg [7:0] discCnt_reg; // Discarded instruction count, wraps

  // Combinational execute results
  reg memWe; // Instruction writes data memory; takes effect only in execute
  reg [7:0] memWdata;
  reg skipHit; // Skip condition met
  reg tabLast; // Table read from last page

  // Decoded fields of the current instruction
  wire [4:0] opCode = instr_reg[`IEX_F_OP_HI:`IEX_F_OP_LO];
  wire [2:0] bitSel = instr_reg[`IEX_F_BIT_HI:`IEX_F_BIT_LO];
  wire [7:0] memAdr = instr_reg[`IEX_F_ADR_HI:`IEX_F_ADR_LO];
  wire [7:0] immVal = instr_reg[`IEX_F_IMM_HI:`IEX_F_IMM_LO];
  wire [7:0] memVal = dmem[memAdr];
  wire selBit = memVal[bitSel];

  // Shared subtractor: operand is memory or immediate
  wire [7:0] subOp = (opCode == `IEX_OP_SUB_IMM) ? immVal : memVal;
  wire [8:0] subSum = {1'b0, acc_reg} + {1'b0, ~subOp} + 9'h001;
  wire [4:0] subLow = {1'b0, acc_reg[3:0]} + {1'b0, ~subOp[3:0]} + 5'h01;
  wire [7:0] subRes = subSum[7:0];
  // Overflow: like-signed addends giving a differently signed result
  wire subOv = (acc_reg[7] == ~subOp[7]) && (subRes[7] != acc_reg[7]);

  // Increment, decrement, swap and xor results
  wire [7:0] incVal = memVal + 8'h01;
  wire [7:0] decVal = memVal - 8'h01;
  wire [7:0] swapVal = {memVal[3:0], memVal[7:4]};
  wire [7:0] xorVal = acc_reg ^ memVal;

  // Bus decode
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr = busReq & wb_we_i;
  // Writes wait while an instruction runs, so core and bus never race
  wire busTake = busReq & ~(busWr & (state_reg != ST_IDLE));
  wire wrExec = busTake & wb_we_i & (wb_adr_i == `IEX_OFS_EXEC) & (&wb_sel_i[2:0]);
  wire issue = wrExec & ~skipPend_reg;

  // Execute decode: results, flags and skip
  always @* begin
    memWe = 1'b0;
    memWdata = memVal;
    skipHit = 1'b0;
    tabLast = 1'b0;
    acc_next = acc_reg;
    flagC_next = flagC_reg;
    flagAc_next = flagAc_reg;
    flagZ_next = flagZ_reg;
    flagOv_next = flagOv_reg;
    case (opCode)
      `IEX_OP_DEC_ACC_SKZ: begin
        acc_next = decVal;
        skipHit = (decVal == 8'h00);
      end
      `IEX_OP_SET_BYTE: begin
        memWe = 1'b1;
        memWdata = `IEX_ALL_ONES;
      end
      `IEX_OP_SET_BIT: begin
        memWe = 1'b1;
        memWdata[bitSel] = 1'b1;
      end
      `IEX_OP_INC_SKZ: begin
        memWe = 1'b1;
        memWdata = incVal;
        skipHit = (incVal == 8'h00);
      end
      `IEX_OP_INC_ACC_SKZ: begin
        acc_next = incVal;
        skipHit = (incVal == 8'h00);
      end
      `IEX_OP_SKIP_BIT_NZ: begin
        skipHit = selBit;
      end
      `IEX_OP_SUB_ACC, `IEX_OP_SUB_IMM: begin
        acc_next = subRes;
        flagC_next = subSum[8];
        flagAc_next = subLow[4];
        flagZ_next = (subRes == 8'h00);
        flagOv_next = subOv;
      end
      `IEX_OP_SUB_MEM: begin
        memWe = 1'b1;
        memWdata = subRes;
        flagC_next = subSum[8];
        flagAc_next = subLow[4];
        flagZ_next = (subRes == 8'h00);
        flagOv_next = subOv;
      end
      `IEX_OP_SWAP_MEM: begin
        memWe = 1'b1;
        memWdata = swapVal;
      end
      `IEX_OP_SWAP_ACC: begin
        acc_next = swapVal;
      end
      `IEX_OP_SKIP_ZERO: begin
        skipHit = (memVal == 8'h00);
      end
      `IEX_OP_COPY_ACC_SKZ: begin
        acc_next = memVal;
        skipHit = (memVal == 8'h00);
      end
      `IEX_OP_SKIP_BIT_Z: begin
        skipHit = ~selBit;
      end
      `IEX_OP_TAB_LAST: begin
        tabLast = 1'b1;
      end
      `IEX_OP_XOR_ACC: begin
        acc_next = xorVal;
        flagZ_next = (xorVal == 8'h00);
      end
      `IEX_OP_XOR_MEM: begin
        memWe = 1'b1;
        memWdata = xorVal;
        flagZ_next = (xorVal == 8'h00);
      end
      default: begin
        // Current-page table read and unknown codes change nothing here
        skipHit = 1'b0;
      end
    endcase
  end

  // Next state
  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = issue ? ST_EXEC : ST_IDLE;
      end
      ST_EXEC: begin
        if (opCode == `IEX_OP_TAB_CUR || opCode == `IEX_OP_TAB_LAST) begin
          state_next = ST_TAB;
        end else if (skipHit) begin
          state_next = ST_DUMMY;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_TAB: begin
        state_next = ST_IDLE;
      end
      ST_DUMMY: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Data memory writes: core in execute or table, else bus window
  always @(posedge mclk) begin
    if (ce) begin
      if (state_reg == ST_EXEC && memWe) begin
        dmem[memAdr] <= memWdata;
      end else if (state_reg == ST_TAB) begin
        dmem[memAdr] <= pmData[7:0];
      end else if (busTake && wb_we_i && wb_adr_i == `IEX_OFS_DDATA && wb_sel_i[0]) begin
        dmem[daddr_reg] <= wb_dat_i[7:0];
      end
    end
  end

  // Control state, accumulator, flags and table registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      instr_reg <= 24'h000000;
      acc_reg <= `IEX_RST_BYTE;
      tptr_reg <= `IEX_RST_BYTE;
      thigh_reg <= `IEX_RST_BYTE;
      page_reg <= {PAGE_W{1'b0}};
      daddr_reg <= `IEX_RST_BYTE;
      flagC_reg <= 1'b0;
      flagAc_reg <= 1'b0;
      flagZ_reg <= 1'b0;
      flagOv_reg <= 1'b0;
      skipPend_reg <= 1'b0;
      discCnt_reg <= `IEX_RST_BYTE;
      pmAddr <= {PM_ADDR_WIDTH{1'b0}};
      pmRd <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      busy <= (state_next != ST_IDLE);
      // Fetch: the instruction after a skip is dropped, not run
      if (issue) begin
        instr_reg <= wb_dat_i[23:0];
      end
      if (wrExec && skipPend_reg) begin
        skipPend_reg <= 1'b0;
        discCnt_reg <= discCnt_reg + 8'h01;
      end
      if (state_reg == ST_EXEC) begin
        acc_reg <= acc_next;
        flagC_reg <= flagC_next;
        flagAc_reg <= flagAc_next;
        flagZ_reg <= flagZ_next;
        flagOv_reg <= flagOv_next;
        if (skipHit) begin
          skipPend_reg <= 1'b1;
        end
        if (state_next == ST_TAB) begin
          // Last page is all ones above the pointer
          pmAddr <= {(tabLast ? {PAGE_W{1'b1}} : page_reg), tptr_reg};
          pmRd <= 1'b1;
        end
      end else if (state_reg == ST_TAB) begin
        thigh_reg <= pmData[PM_DATA_WIDTH-1:8];
        pmRd <= 1'b0;
      end else if (busTake && wb_we_i) begin
        // Bus register writes, only while idle
        case (wb_adr_i)
          `IEX_OFS_STATUS: begin
            if (wb_sel_i[0]) begin
              flagC_reg <= wb_dat_i[`IEX_ST_C];
              flagAc_reg <= wb_dat_i[`IEX_ST_AC];
              flagZ_reg <= wb_dat_i[`IEX_ST_Z];
              flagOv_reg <= wb_dat_i[`IEX_ST_OV];
            end
          end
          `IEX_OFS_ACC: begin
            if (wb_sel_i[0]) begin
              acc_reg <= wb_dat_i[7:0];
            end
          end
          `IEX_OFS_TPTR: begin
            if (wb_sel_i[0]) begin
              tptr_reg <= wb_dat_i[7:0];
            end
          end
          `IEX_OFS_PAGE: begin
            if (wb_sel_i[0]) begin
              page_reg <= wb_dat_i[PAGE_W-1:0];
            end
          end
          `IEX_OFS_DADDR: begin
            if (wb_sel_i[0]) begin
              daddr_reg <= wb_dat_i[7:0];
            end
          end
          default: begin
            // Read-only or unmapped: write ignored
            daddr_reg <= daddr_reg;
          end
        endcase
      end
    end
  end

  // Bus answer: ack one cycle after a taken request, data with it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `IEX_RST_WORD;
    end else if (ce) begin
      wb_ack_o <= busTake;
      if (busTake && !wb_we_i) begin
        case (wb_adr_i)
          `IEX_OFS_EXEC: begin
            wb_dat_o <= {8'h00, instr_reg};
          end
          `IEX_OFS_STATUS: begin
            wb_dat_o <= {16'h0000, discCnt_reg, flagOv_reg, flagZ_reg, flagAc_reg, flagC_reg,
                         2'b00, skipPend_reg, busy};
          end
          `IEX_OFS_ACC: begin
            wb_dat_o <= {24'h000000, acc_reg};
          end
          `IEX_OFS_TPTR: begin
            wb_dat_o <= {24'h000000, tptr_reg};
          end
          `IEX_OFS_THIGH: begin
            wb_dat_o <= {24'h000000, thigh_reg};
          end
          `IEX_OFS_PAGE: begin
            wb_dat_o <= {{(32-PAGE_W){1'b0}}, page_reg};
          end
          `IEX_OFS_DADDR: begin
            wb_dat_o <= {24'h000000, daddr_reg};
          end
          `IEX_OFS_DDATA: begin
            wb_dat_o <= {24'h000000, dmem[daddr_reg]};
          end
          default: begin
            // Unmapped reads answer zero
            wb_dat_o <= `IEX_RST_WORD;
          end
        endcase
      end else begin
        wb_dat_o <= `IEX_RST_WORD;
      end
    end
  end

endmodule // iex_core

`default_nettype wire

// ### inc/iex_regs.vh
// Purpose: Register map, field layout, opcodes and reset values of the
//          instruction execution unit.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Definitions only; included by bare name.
`ifndef IEX_REGS_VH
`define IEX_REGS_VH

// Register byte offsets
`define IEX_OFS_EXEC 8'h00
`define IEX_OFS_STATUS 8'h04
`define IEX_OFS_ACC 8'h08
`define IEX_OFS_TPTR 8'h0c
`define IEX_OFS_THIGH 8'h10
`define IEX_OFS_PAGE 8'h14
`define IEX_OFS_DADDR 8'h18
`define IEX_OFS_DDATA 8'h1c

// Instruction word fields in the EXEC register
`define IEX_F_OP_HI 4
`define IEX_F_OP_LO 0
`define IEX_F_BIT_HI 7
`define IEX_F_BIT_LO 5
`define IEX_F_ADR_HI 15
`define IEX_F_ADR_LO 8
`define IEX_F_IMM_HI 23
`define IEX_F_IMM_LO 16

// Status register bit positions
`define IEX_ST_BUSY 0
`define IEX_ST_SKIPPEND 1
`define IEX_ST_C 4
`define IEX_ST_AC 5
`define IEX_ST_Z 6
`define IEX_ST_OV 7
`define IEX_ST_DISC_LO 8
`define IEX_ST_DISC_HI 15

// Opcodes
`define IEX_OP_DEC_ACC_SKZ 5'h00
`define IEX_OP_SET_BYTE 5'h01
`define IEX_OP_SET_BIT 5'h02
`define IEX_OP_INC_SKZ 5'h03
`define IEX_OP_INC_ACC_SKZ 5'h04
`define IEX_OP_SKIP_BIT_NZ 5'h05
`define IEX_OP_SUB_ACC 5'h06
`define IEX_OP_SUB_MEM 5'h07
`define IEX_OP_SUB_IMM 5'h08
`define IEX_OP_SWAP_MEM 5'h09
`define IEX_OP_SWAP_ACC 5'h0a
`define IEX_OP_SKIP_ZERO 5'h0b
`define IEX_OP_COPY_ACC_SKZ 5'h0c
`define IEX_OP_SKIP_BIT_Z 5'h0d
`define IEX_OP_TAB_CUR 5'h0e
`define IEX_OP_TAB_LAST 5'h0f
`define IEX_OP_XOR_ACC 5'h10
`define IEX_OP_XOR_MEM 5'h11

// Values
`define IEX_ALL_ONES 8'hff
`define IEX_RST_BYTE 8'h00
`define IEX_RST_WORD 32'h0000_0000

`endif

// ### verification/iex_core_properties.sv
// Purpose: Bus, busy and table-fetch timing checks for the execution unit.
// Assumes: One request at a time; clock enable pauses the checks.
// Notes: Bound onto every iex_core instance.
`include "iex_regs.vh"
`default_nettype none
module iex_core_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pmRd,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // A frozen enable stalls all state, so checks pause with it
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b || !ce);
  // Answer is a single pulse tied to a live request
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  // Reads and idle writes are answered in the next cycle
  chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !(wb_we_i && busy) |=> wb_ack_o)
    else $error("late ack");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
  // Dummy or fetch cycle adds exactly one cycle
  chk_busy_bound: assert property (busy [*2] |=> !busy) else $error("busy too long");
  chk_busy_start: assert property ($rose(busy) |-> wb_ack_o && $past(wb_adr_i) == `IEX_OFS_EXEC)
    else $error("busy without issue");
  // Fetch is the second and last cycle of a table run
  chk_fetch_run: assert property (pmRd |-> busy && $past(busy)) else $error("fetch outside run");
  chk_fetch_end: assert property (pmRd |=> !pmRd && !busy) else $error("fetch not last");
  cover property (pmRd);
  cover property (busy [*2]);
  cover property (wb_ack_o && wb_we_i && !busy);
endmodule // iex_core_properties
bind iex_core iex_core_properties u_props (.mclk(mclk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pmRd(pmRd), .busy(busy));
`default_nettype wire

// ### verification/iex_core_tb.sv
// Purpose: Self-checking bench for the instruction execution unit.
// Assumes: Classic single Wishbone cycles; clock enable held high.
// Notes: Each case loads memory cell 20h, accumulator and flags, then runs one instruction.
`include "iex_regs.vh"
`default_nettype none
module iex_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0; // System clock
  logic rst_b = 1'h0; // Reset, active low
  logic req = 1'h0; // Cycle and strobe rise together
  logic we = 1'h0; // Write strobe
  logic [7:0] adr = 8'h00; // Register offset
  logic [31:0] dat = 32'h0; // Write data
  logic [31:0] rdData; // Read data
  logic ack, busy, pmRd; // Answer, run and fetch flags
  logic [11:0] pmAddr; // Program address
  logic [15:0] pmData; // Program word
  logic [31:0] q; // Last read
  int fails = 0; // Mismatches
  int comparisons = 0; // Comparisons made
  int skips = 0; // Expected discards
  // 20 ns period
  always #10 mclk = ~mclk;
  iex_core DUT (.mclk(mclk), .rst_b(rst_b), .ce(1'h1), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdData), .wb_ack_o(ack), .pmAddr(pmAddr),
    .pmRd(pmRd), .pmData(pmData), .busy(busy));
  iex_pmem_model u_pmem (.pmAddr(pmAddr), .pmRd(pmRd), .pmData(pmData));
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; ack and data sampled at the edge, released right after it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge mclk);
    req <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    t = 0;
    // Reading before the edge's updates gives the value the slave showed
    do begin
      @(posedge mclk);
      t++;
    end while (ack !== 1'h1 && t < 40);
    r = rdData;
    req <= 1'h0;
    we <= 1'h0;
    if (ack !== 1'h1) begin
      fails++;
      stop_test();
    end
  endtask
  // Runs one instruction; in and out are {mem, acc, flags}
  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm, input logic [19:0] in,
      input logic [19:0] out, input logic sk);
    int n;
    bus(1'h1, `IEX_OFS_DADDR, 32'h0000_0020, q);
    bus(1'h1, `IEX_OFS_DDATA, {24'h0, in[19:12]}, q);
    bus(1'h1, `IEX_OFS_ACC, {24'h0, in[11:4]}, q);
    bus(1'h1, `IEX_OFS_STATUS, {24'h0, in[3:0], 4'h0}, q);
    bus(1'h1, `IEX_OFS_EXEC, {8'h00, imm, 8'h20, b, op}, q);
    n = 0;
    #1;
    // Busy past the answer edge counts the dummy or fetch cycle
    while (busy === 1'h1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // A run that never ends is a hang, not a slow answer
    if (n >= 8) begin
      fails++;
      stop_test();
    end
    cmp(n, (sk || op[4:1] == 4'h7) ? 1 : 0);
    bus(1'h0, `IEX_OFS_DDATA, 32'h0, q);
    cmp(q, {24'h0, out[19:12]});
    bus(1'h0, `IEX_OFS_ACC, 32'h0, q);
    cmp(q, {24'h0, out[11:4]});
    bus(1'h0, `IEX_OFS_STATUS, 32'h0, q);
    cmp({q[7:4], q[1]}, {out[3:0], sk});
    // After a skip the next issued instruction must leave accumulator and flags unchanged and only raise the discard count
    if (sk) begin
      skips++;
      bus(1'h1, `IEX_OFS_EXEC, {8'h00, 8'h01, 8'h20, 3'h0, `IEX_OP_SUB_IMM}, q);
      bus(1'h0, `IEX_OFS_ACC, 32'h0, q);
      cmp(q, {24'h0, out[11:4]});
      bus(1'h0, `IEX_OFS_STATUS, 32'h0, q);
      cmp({q[15:8], q[7:4], q[1]}, {skips[7:0], out[3:0], 1'h0});
    end
  endtask
  task automatic sc_table;
    bus(1'h0, `IEX_OFS_THIGH, 32'h0, q);
    cmp(q, 32'h0);
    bus(1'h1, `IEX_OFS_TPTR, 32'h0000_0047, q);
    bus(1'h1, `IEX_OFS_PAGE, 32'h0000_0002, q);
    run(`IEX_OP_TAB_CUR, 3'h0, 8'h00, 20'h00113, 20'h7b113, 1'h0);
    bus(1'h0, `IEX_OFS_THIGH, 32'h0, q);
    cmp(q, 32'h0000_0024);
    run(`IEX_OP_TAB_LAST, 3'h0, 8'h00, 20'h00113, 20'h7b113, 1'h0);
    // Read-only place ignores the write; unmapped place reads zero
    bus(1'h1, `IEX_OFS_THIGH, 32'h0, q);
    bus(1'h0, `IEX_OFS_THIGH, 32'h0, q);
    cmp(q, 32'h0000_00f4);
    bus(1'h0, 8'h40, 32'h0, q);
    cmp(q, 32'h0);
  endtask
  task automatic sc_step;
    run(`IEX_OP_DEC_ACC_SKZ, 3'h0, 8'h00, 20'h0133f, 20'h0100f, 1'h1);
    run(`IEX_OP_DEC_ACC_SKZ, 3'h0, 8'h00, 20'h00000, 20'h00ff0, 1'h0);
    run(`IEX_OP_INC_SKZ, 3'h0, 8'h00, 20'hff44f, 20'h0044f, 1'h1);
    run(`IEX_OP_INC_SKZ, 3'h0, 8'h00, 20'h7f440, 20'h80440, 1'h0);
    run(`IEX_OP_INC_ACC_SKZ, 3'h0, 8'h00, 20'hff330, 20'hff000, 1'h1);
    run(`IEX_OP_INC_ACC_SKZ, 3'h0, 8'h00, 20'h10330, 20'h10110, 1'h0);
  endtask
  task automatic sc_set;
    run(`IEX_OP_SET_BYTE, 3'h0, 8'h00, 20'h1200a, 20'hff00a, 1'h0);
    for (int i = 0; i < 8; i++) begin
      run(`IEX_OP_SET_BIT, i[2:0], 8'h00, 20'h5a005, {8'h5a | (8'h01 << i), 12'h005}, 1'h0);
    end
  endtask
  task automatic sc_tests;
    run(`IEX_OP_SKIP_BIT_NZ, 3'h6, 8'h00, 20'h40123, 20'h40123, 1'h1);
    run(`IEX_OP_SKIP_BIT_NZ, 3'h6, 8'h00, 20'hbf123, 20'hbf123, 1'h0);
    run(`IEX_OP_SKIP_BIT_Z, 3'h2, 8'h00, 20'hfb12c, 20'hfb12c, 1'h1);
    run(`IEX_OP_SKIP_BIT_Z, 3'h2, 8'h00, 20'h0412c, 20'h0412c, 1'h0);
    run(`IEX_OP_SKIP_ZERO, 3'h0, 8'h00, 20'h00120, 20'h00120, 1'h1);
    run(`IEX_OP_SKIP_ZERO, 3'h0, 8'h00, 20'h01120, 20'h01120, 1'h0);
    run(`IEX_OP_COPY_ACC_SKZ, 3'h0, 8'h00, 20'h00770, 20'h00000, 1'h1);
    run(`IEX_OP_COPY_ACC_SKZ, 3'h0, 8'h00, 20'h9c770, 20'h9c9c0, 1'h0);
  endtask
  task automatic sc_arith;
    run(`IEX_OP_SUB_ACC, 3'h0, 8'h00, 20'h0605f, 20'h06ff0, 1'h0);
    run(`IEX_OP_SUB_ACC, 3'h0, 8'h00, 20'h33338, 20'h33007, 1'h0);
    run(`IEX_OP_SUB_MEM, 3'h0, 8'h00, 20'h01806, 20'h7f809, 1'h0);
    run(`IEX_OP_SUB_IMM, 3'h0, 8'h01, 20'h55806, 20'h557f9, 1'h0);
    run(`IEX_OP_SWAP_MEM, 3'h0, 8'h00, 20'ha53cf, 20'h5a3cf, 1'h0);
    run(`IEX_OP_SWAP_ACC, 3'h0, 8'h00, 20'ha53c0, 20'ha55a0, 1'h0);
    run(`IEX_OP_XOR_ACC, 3'h0, 8'h00, 20'hf0f00, 20'hf0004, 1'h0);
    run(`IEX_OP_XOR_MEM, 3'h0, 8'h00, 20'h3c3cb, 20'h003cf, 1'h0);
  endtask
  // Reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    sc_table();
    sc_step();
    sc_set();
    sc_tests();
    sc_arith();
    stop_test();
  end
endmodule // iex_core_tb
`default_nettype wire

// ### verification/iex_pmem_model.sv
// Purpose: Program memory seen by the table fetch.
// Assumes: Twelve address bits, sixteen data bits.
// Notes: Each word encodes its address, so a wrong page shows.
`default_nettype none
module iex_pmem_model (
  input wire logic [11:0] pmAddr,
  input wire logic pmRd,
  output logic [15:0] pmData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word; // Content at the current address
  // High byte from page and pointer top, low byte scrambled pointer
  assign word = {pmAddr[11:4], pmAddr[7:0] ^ 8'h3c};
  // Outside a fetch the bus shows no stale word
  assign pmData = pmRd ? word : ~word;
endmodule // iex_pmem_model
`default_nettype wire
